// ===== include/exit_rev_pkg.sv
// Constants, register map and state encoding for the exit/reverse motor controller
package exit_rev_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_MHZ = 50;
  localparam int US_NS = 1000;
  localparam int US_CYCLES = (US_NS * CLK_MHZ) / 1000;
  localparam int DLY_TICK_US = 100;
  localparam int DLY_TICK_CYCLES = DLY_TICK_US * US_CYCLES;

  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int PER_W = 16;
  localparam int ADDR_W = 8;

  // ----------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_SHEET = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_EXIT_RATE = 8'h0C;
  localparam logic [7:0] OFF_REV_NORM = 8'h10;
  localparam logic [7:0] OFF_REV_HIGH = 8'h14;
  localparam logic [7:0] OFF_SB_DELAY = 8'h18;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CTRL_EXIT_RUN = 0;
  localparam int CTRL_REV_RUN = 1;
  localparam int CTRL_REV_DIR = 2;
  localparam int SHEET_REVERSE = 0;
  localparam int SHEET_DUPLEX = 1;

  // ----------------------------------------
  // Reset values (periods in microseconds)
  // ----------------------------------------
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic [15:0] EXIT_RATE_RST = 16'h03E8;
  localparam logic [15:0] REV_NORM_RST = 16'h03E8;
  localparam logic [15:0] REV_HIGH_RST = 16'h01F4;
  localparam logic [15:0] SB_DELAY_RST = 16'h0064;
  localparam logic [15:0] START_PERIOD = 16'h0FA0;
  localparam logic [15:0] RAMP_STEP = 16'h0010;

  // ----------------------------------------
  // Sheet sequencer states
  // ----------------------------------------
  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_TAIL = 3'h1,
    S_DELAY = 3'h3,
    S_STOP = 3'h2,
    S_BACK = 3'h6,
    S_HAND = 3'h7,
    S_EXIT = 3'h5,
    S_STRAIGHT = 3'h4
  } seq_state_e;

endpackage

// ===== include/ramp_if.sv
// Carrier between the controller and one stepper speed ramp
`timescale 1ns/100ps
`default_nettype none
interface ramp_if #(parameter int W = 16);
  logic run;
  logic [W-1:0] target;
  logic step;
  logic at_speed;
  logic stopped;
  modport ctrl (output run, output target, input step, input at_speed, input stopped);
  modport ramp (input run, input target, output step, output at_speed, output stopped);
endinterface
`default_nettype wire

// ===== src/stepper_ramp.sv
// Step-period generator with linear acceleration and deceleration
`timescale 1ns/100ps
`default_nettype none
module stepper_ramp #(
  parameter int W = 16,
  parameter logic [W-1:0] START = 16'h0FA0,
  parameter logic [W-1:0] STEP = 16'h0010
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Microsecond enable
  input wire logic tick_us,
  // Controller side
  ramp_if.ramp r
);

  if (STEP == '0 || START == '0 || W < 4) begin : g_bad_param
    $error("stepper_ramp: START and STEP must be nonzero, W at least 4");
  end

  logic moving;
  logic [W-1:0] cur;
  logic [W-1:0] cnt;
  logic [W-1:0] goal;
  logic [W-1:0] next_cur;

  // One increment of the period toward the goal, never overshooting
  function automatic logic [W-1:0] approach(input logic [W-1:0] c, input logic [W-1:0] g);
    logic [W:0] up;
    up = {1'b0, c} + {1'b0, STEP};
    if (c > g && (c - g) > STEP) begin
      approach = c - STEP;
    end else if (c < g && up < {1'b0, g}) begin
      approach = up[W-1:0];
    end else begin
      approach = g;
    end
  endfunction

  assign next_cur = approach(cur, goal);

  // ----------------------------------------
  // Goal lags run by one cycle so at_speed falls before the period moves
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      goal <= START;
    end else begin
      goal <= r.run ? r.target : START;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      moving <= 1'b0;
      cur <= START;
      cnt <= START;
      r.step <= 1'b0;
    end else begin
      r.step <= 1'b0;
      if (!moving) begin
        if (r.run) begin
          moving <= 1'b1;
          cur <= START;
          cnt <= START;
        end
      end else if (tick_us) begin
        if (cnt <= 1) begin
          r.step <= 1'b1;
          cur <= next_cur;
          cnt <= next_cur;
          if (!r.run && cur >= START) begin
            moving <= 1'b0;
          end
        end else begin
          cnt <= cnt - 1'b1;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r.at_speed <= 1'b0;
      r.stopped <= 1'b1;
    end else begin
      r.at_speed <= moving && r.run && cur == goal && goal == r.target;
      r.stopped <= !moving;
    end
  end

endmodule // stepper_ramp
`default_nettype wire

// ===== src/exit_reverse_path_motor_ctrl.sv
// Exit/reverse path controller: gate, sheet sequencing, two stepper drives, APB registers
// Contract
// - Gate rests toward reverse path; energise solenoid only for sheets not reversed.
// - Fuser sensor trailing edge raises reverse-path speed to high setting.
// - After speed-up, wait configured delay, then reverse path rollers for switchback.
// - Exiting sheet after switchback keeps high speed until discharged at exit roller.
// - Duplex sheet goes to horizontal transport; speed returns to normal there.
// - Duplex second pass: gate switched, sheet goes straight out through exit roller.
// - Exit motor driven by four separate phase outputs toward its driver.
// - Exit motor speed set by timing between successive phase outputs.
// - Exit speed-state low while ramping, high at constant speed.
// - Reverse motor speed set by reference clock frequency.
// - Direction output low for forward, high for reverse rotation.
// - Reverse speed-state low while ramping, high at constant speed, either direction.
//
// Our own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module exit_reverse_path_motor_ctrl #(
  parameter int TICK_CYCLES = exit_rev_pkg::DLY_TICK_CYCLES,
  parameter int US_TICK = exit_rev_pkg::US_CYCLES
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Paper sensors, high while paper is present
  input wire logic fuser_transport_sensor,
  input wire logic reverse_sensor_1,
  input wire logic reverse_sensor_2,
  // Gate
  output logic gate_solenoid,
  // Exit motor driver
  output logic exit_phase_a,
  output logic exit_phase_b,
  output logic exit_phase_c,
  output logic exit_phase_d,
  output logic exit_const_speed_n,
  // Reverse motor driver
  output logic rev_ref_clock,
  output logic rev_enable_n,
  output logic rev_const_speed_n,
  output logic rev_direction
);

  if (TICK_CYCLES < 1 || TICK_CYCLES > 8192 || US_TICK < 1 || US_TICK > 64) begin : g_bad_tick
    $error("exit_reverse_path_motor_ctrl: TICK_CYCLES must be 1 to 8192, US_TICK 1 to 64");
  end

  localparam int PW = exit_rev_pkg::PER_W;

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [2:0] ctrl;
  logic [PW-1:0] exit_rate;
  logic [PW-1:0] rev_norm;
  logic [PW-1:0] rev_high;
  logic [PW-1:0] sb_delay;
  logic sheet_reverse;
  logic sheet_duplex;
  exit_rev_pkg::seq_state_e state;
  exit_rev_pkg::seq_state_e next_state;
  logic [5:0] us_cnt;
  logic tick_us;
  logic [12:0] dly_pre;
  logic tick_dly;
  logic [PW-1:0] dly_cnt;
  logic [2:0] sens_meta;
  logic [2:0] sens;
  logic [2:0] sens_q;
  logic fuser_tail;
  logic rs1_tail;
  logic rs2_head;
  logic [1:0] exit_idx;
  logic seq_dir;
  logic apb_wr;
  logic sheet_go;
  logic [31:0] next_prdata;
  logic next_err;

  ramp_if #(.W(PW)) exit_r ();
  ramp_if #(.W(PW)) rev_r ();

  // ----------------------------------------
  // Rate dividers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      us_cnt <= 6'h00;
      tick_us <= 1'b0;
    end else begin
      tick_us <= us_cnt == 6'(US_TICK - 1);
      us_cnt <= (us_cnt == 6'(US_TICK - 1)) ? 6'h00 : us_cnt + 6'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dly_pre <= 13'h0000;
      tick_dly <= 1'b0;
    end else begin
      tick_dly <= dly_pre == 13'(TICK_CYCLES - 1);
      dly_pre <= (dly_pre == 13'(TICK_CYCLES - 1)) ? 13'h0000 : dly_pre + 13'h0001;
    end
  end

  // ----------------------------------------
  // Sensor synchronisers and edges
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sens_meta <= 3'h0;
      sens <= 3'h0;
      sens_q <= 3'h0;
    end else begin
      sens_meta <= {reverse_sensor_2, reverse_sensor_1, fuser_transport_sensor};
      sens <= sens_meta;
      sens_q <= sens;
    end
  end

  assign fuser_tail = sens_q[0] && !sens[0];
  assign rs1_tail = sens_q[1] && !sens[1];
  assign rs2_head = !sens_q[2] && sens[2];

  // ----------------------------------------
  // APB slave, no wait states: pready rises in the first access cycle
  // ----------------------------------------
  assign apb_wr = psel && penable && pready && pwrite;
  assign sheet_go = apb_wr && paddr == exit_rev_pkg::OFF_SHEET && state == exit_rev_pkg::S_IDLE;

  always_comb begin
    next_prdata = 32'h0000_0000;
    next_err = 1'b0;
    if (paddr == exit_rev_pkg::OFF_CTRL) begin
      next_prdata = {29'h0, ctrl};
    end else if (paddr == exit_rev_pkg::OFF_SHEET) begin
      next_prdata = {30'h0, sheet_duplex, sheet_reverse};
    end else if (paddr == exit_rev_pkg::OFF_STATUS) begin
      next_prdata = {20'h0, sens, rev_direction, rev_const_speed_n, !rev_enable_n,
                     exit_const_speed_n, gate_solenoid, state != exit_rev_pkg::S_IDLE, state};
    end else if (paddr == exit_rev_pkg::OFF_EXIT_RATE) begin
      next_prdata = {16'h0, exit_rate};
    end else if (paddr == exit_rev_pkg::OFF_REV_NORM) begin
      next_prdata = {16'h0, rev_norm};
    end else if (paddr == exit_rev_pkg::OFF_REV_HIGH) begin
      next_prdata = {16'h0, rev_high};
    end else if (paddr == exit_rev_pkg::OFF_SB_DELAY) begin
      next_prdata = {16'h0, sb_delay};
    end else begin
      next_err = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && next_err;
      prdata <= (psel && !penable && !pwrite) ? next_prdata : 32'h0000_0000;
    end
  end

  // Rates and delay are software settings; writes to the sheet register while busy are dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= exit_rev_pkg::CTRL_RST;
      exit_rate <= exit_rev_pkg::EXIT_RATE_RST;
      rev_norm <= exit_rev_pkg::REV_NORM_RST;
      rev_high <= exit_rev_pkg::REV_HIGH_RST;
      sb_delay <= exit_rev_pkg::SB_DELAY_RST;
      sheet_reverse <= 1'b0;
      sheet_duplex <= 1'b0;
    end else if (apb_wr) begin
      if (paddr == exit_rev_pkg::OFF_CTRL) begin
        ctrl <= pwdata[2:0];
      end else if (paddr == exit_rev_pkg::OFF_EXIT_RATE) begin
        exit_rate <= pwdata[PW-1:0];
      end else if (paddr == exit_rev_pkg::OFF_REV_NORM) begin
        rev_norm <= pwdata[PW-1:0];
      end else if (paddr == exit_rev_pkg::OFF_REV_HIGH) begin
        rev_high <= pwdata[PW-1:0];
      end else if (paddr == exit_rev_pkg::OFF_SB_DELAY) begin
        sb_delay <= pwdata[PW-1:0];
      end else if (sheet_go) begin
        sheet_reverse <= pwdata[exit_rev_pkg::SHEET_REVERSE];
        sheet_duplex <= pwdata[exit_rev_pkg::SHEET_DUPLEX];
      end
    end
  end

  // ----------------------------------------
  // Sheet sequencer
  // ----------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      exit_rev_pkg::S_IDLE: begin
        if (sheet_go) begin
          next_state = pwdata[exit_rev_pkg::SHEET_REVERSE] ? exit_rev_pkg::S_TAIL
                                                           : exit_rev_pkg::S_STRAIGHT;
        end
      end
      exit_rev_pkg::S_TAIL: begin
        if (fuser_tail) begin
          next_state = exit_rev_pkg::S_DELAY;
        end
      end
      exit_rev_pkg::S_DELAY: begin
        if (dly_cnt == '0) begin
          next_state = exit_rev_pkg::S_STOP;
        end
      end
      exit_rev_pkg::S_STOP: begin
        if (rev_r.stopped && !rev_r.run) begin
          next_state = exit_rev_pkg::S_BACK;
        end
      end
      exit_rev_pkg::S_BACK: begin
        next_state = sheet_duplex ? exit_rev_pkg::S_HAND : exit_rev_pkg::S_EXIT;
      end
      exit_rev_pkg::S_HAND: begin
        if (rs2_head) begin
          next_state = exit_rev_pkg::S_IDLE;
        end
      end
      exit_rev_pkg::S_EXIT: begin
        if (rs1_tail) begin
          next_state = exit_rev_pkg::S_IDLE;
        end
      end
      exit_rev_pkg::S_STRAIGHT: begin
        if (fuser_tail) begin
          next_state = exit_rev_pkg::S_IDLE;
        end
      end
      default: next_state = exit_rev_pkg::S_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= exit_rev_pkg::S_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Switchback delay counted in coarse ticks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dly_cnt <= '0;
    end else if (state == exit_rev_pkg::S_TAIL) begin
      dly_cnt <= sb_delay;
    end else if (state == exit_rev_pkg::S_DELAY && tick_dly && dly_cnt != '0) begin
      dly_cnt <= dly_cnt - 1'b1;
    end
  end

  // Rollers may only reverse from standstill, so seq_dir turns to reverse in S_STOP only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_dir <= 1'b0;
    end else if (state == exit_rev_pkg::S_IDLE || state == exit_rev_pkg::S_TAIL) begin
      seq_dir <= 1'b0;
    end else if (state == exit_rev_pkg::S_STOP && rev_r.stopped) begin
      seq_dir <= 1'b1;
    end
  end

  // ----------------------------------------
  // Motor requests
  // ----------------------------------------
  always_comb begin
    exit_r.target = exit_rate;
    exit_r.run = ctrl[exit_rev_pkg::CTRL_EXIT_RUN] || state == exit_rev_pkg::S_EXIT
                 || state == exit_rev_pkg::S_STRAIGHT;
    // Forward feed waits until a reverse run has come to rest
    rev_r.run = ctrl[exit_rev_pkg::CTRL_REV_RUN] || state == exit_rev_pkg::S_BACK
                || state == exit_rev_pkg::S_HAND || state == exit_rev_pkg::S_EXIT
                || ((state == exit_rev_pkg::S_TAIL || state == exit_rev_pkg::S_DELAY) && !rev_direction);
    if (state == exit_rev_pkg::S_DELAY || state == exit_rev_pkg::S_BACK
        || state == exit_rev_pkg::S_EXIT) begin
      rev_r.target = rev_high;
    end else begin
      rev_r.target = rev_norm;
    end
  end

  stepper_ramp #(
    .W(PW),
    .START(exit_rev_pkg::START_PERIOD),
    .STEP(exit_rev_pkg::RAMP_STEP)
  ) u_exit_ramp (
    .pclk(pclk),
    .presetn(presetn),
    .tick_us(tick_us),
    .r(exit_r.ramp)
  );

  stepper_ramp #(
    .W(PW),
    .START(exit_rev_pkg::START_PERIOD),
    .STEP(exit_rev_pkg::RAMP_STEP)
  ) u_rev_ramp (
    .pclk(pclk),
    .presetn(presetn),
    .tick_us(tick_us),
    .r(rev_r.ramp)
  );

  // ----------------------------------------
  // Output pins
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_solenoid <= 1'b0;
    end else begin
      gate_solenoid <= state == exit_rev_pkg::S_STRAIGHT;
    end
  end

  // Wave drive: one phase at a time, advanced on each step
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      exit_idx <= 2'h0;
      exit_phase_a <= 1'b0;
      exit_phase_b <= 1'b0;
      exit_phase_c <= 1'b0;
      exit_phase_d <= 1'b0;
    end else begin
      if (exit_r.step) begin
        exit_idx <= exit_idx + 2'h1;
      end
      exit_phase_a <= !exit_r.stopped && exit_idx == 2'h0;
      exit_phase_b <= !exit_r.stopped && exit_idx == 2'h1;
      exit_phase_c <= !exit_r.stopped && exit_idx == 2'h2;
      exit_phase_d <= !exit_r.stopped && exit_idx == 2'h3;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      exit_const_speed_n <= 1'b0;
      rev_const_speed_n <= 1'b0;
    end else begin
      exit_const_speed_n <= exit_r.at_speed;
      rev_const_speed_n <= rev_r.at_speed;
    end
  end

  // Reference clock toggles per step: frequency is half the step rate
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rev_ref_clock <= 1'b0;
      rev_enable_n <= 1'b1;
      rev_direction <= 1'b0;
    end else begin
      if (rev_r.step) begin
        rev_ref_clock <= !rev_ref_clock;
      end
      rev_enable_n <= rev_r.stopped;
      if (rev_r.stopped) begin
        rev_direction <= (state == exit_rev_pkg::S_IDLE) ? ctrl[exit_rev_pkg::CTRL_REV_DIR]
                                                         : seq_dir;
      end
    end
  end

endmodule // exit_reverse_path_motor_ctrl
`default_nettype wire

// ===== verification/exit_reverse_path_motor_ctrl_properties.sv
// Port assertions for the exit/reverse motor controller
`timescale 1ns/100ps
`default_nettype none
module exit_rev_checker (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Drives
  input wire logic gate_solenoid,
  input wire logic exit_phase_a,
  input wire logic exit_phase_b,
  input wire logic exit_phase_c,
  input wire logic exit_phase_d,
  input wire logic exit_const_speed_n,
  input wire logic rev_ref_clock,
  input wire logic rev_enable_n,
  input wire logic rev_const_speed_n,
  input wire logic rev_direction
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic [3:0] ph = {exit_phase_d, exit_phase_c, exit_phase_b, exit_phase_a};
  property p_ready; psel && !penable |=> pready; endproperty
  a_ready: assert property (p_ready) else $error("no answer after setup");
  property p_once; pready |=> !pready; endproperty
  a_once: assert property (p_once) else $error("answer held too long");
  property p_err; psel && !penable && paddr > 8'h18 |=> pready && pslverr && prdata == 32'h0; endproperty
  a_err: assert property (p_err) else $error("unmapped access not refused");
  property p_quiet; !pready |-> prdata == 32'h0 && !pslverr; endproperty
  a_quiet: assert property (p_quiet) else $error("read bus not quiet");
  property p_onehot; $onehot0(ph); endproperty
  a_onehot: assert property (p_onehot) else $error("exit phases overlap");
  property p_exit_state; ph == 4'h0 |-> !exit_const_speed_n; endproperty
  a_exit_state: assert property (p_exit_state) else $error("exit at speed while stopped");
  property p_rev_state; rev_enable_n |-> !rev_const_speed_n; endproperty
  a_rev_state: assert property (p_rev_state) else $error("reverse at speed while off");
  property p_dir; !rev_enable_n ##1 !rev_enable_n |-> $stable(rev_direction); endproperty
  a_dir: assert property (p_dir) else $error("direction flipped while moving");
  property p_refclk; rev_enable_n [*2] |-> $stable(rev_ref_clock); endproperty
  a_refclk: assert property (p_refclk) else $error("reference clock runs while off");
  property p_rise; $rose(exit_const_speed_n) |-> ph != 4'h0; endproperty
  a_rise: assert property (p_rise) else $error("exit at speed without stepping");
  c_gate: cover property ($rose(gate_solenoid));
  c_back: cover property (!rev_enable_n && rev_direction);
  c_speed: cover property ($rose(rev_const_speed_n));
  c_err: cover property (pslverr);
endmodule // exit_rev_checker
bind exit_reverse_path_motor_ctrl exit_rev_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .gate_solenoid(gate_solenoid), .exit_phase_a(exit_phase_a), .exit_phase_b(exit_phase_b),
  .exit_phase_c(exit_phase_c), .exit_phase_d(exit_phase_d), .exit_const_speed_n(exit_const_speed_n),
  .rev_ref_clock(rev_ref_clock), .rev_enable_n(rev_enable_n), .rev_const_speed_n(rev_const_speed_n),
  .rev_direction(rev_direction));
`default_nettype wire

// ===== verification/exit_rev_far_side.sv
// Behavioural stepper drivers beyond the controller
`timescale 1ns/100ps
`default_nettype none
module exit_rev_far_side (
  // Controller drive
  input wire logic pclk,
  input wire logic rev_ref_clock,
  input wire logic rev_enable_n,
  input wire logic rev_direction,
  input wire logic [3:0] exit_phase,
  // Power stage
  output logic [3:0] exit_power,
  output logic rev_pulse_a,
  output logic rev_pulse_b,
  output logic rev_pulse_a_bar,
  output logic rev_pulse_b_bar
);
  logic [1:0] pos = 2'h0;
  logic ref_q = 1'b0;
  assign exit_power = exit_phase;
  // Each reference edge is one step; a disabled driver holds position
  always @(posedge pclk) begin
    ref_q <= rev_ref_clock;
    if (!rev_enable_n && rev_ref_clock !== ref_q) pos <= rev_direction ? pos - 2'h1 : pos + 2'h1;
  end
  // Power stage dark while disabled
  assign rev_pulse_a = !rev_enable_n && pos[1];
  assign rev_pulse_b = !rev_enable_n && (pos[1] ^ pos[0]);
  assign rev_pulse_a_bar = !rev_enable_n && !pos[1];
  assign rev_pulse_b_bar = !rev_enable_n && !(pos[1] ^ pos[0]);
endmodule // exit_rev_far_side
`default_nettype wire

// ===== verification/test_exit_reverse_path_motor_ctrl.sv
// Self-checking bench for the exit/reverse motor controller
`timescale 1ns/100ps
`default_nettype none
module test_exit_reverse_path_motor_ctrl;
  // ----
  // Signals and model
  // ----
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr, fus, rs1, rs2, rerr;
  logic gate, ecs, rck, ren, rcs, rdir, pa, pb, pab, pbb;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdat, v;
  logic [3:0] pw;
  wire logic [3:0] ph;
  int error_cnt = 0;
  int cmp_count = 0;
  int i, n;
  int m[7] = '{0, 0, 0, 1000, 1000, 500, 100};
  int cfg[7] = '{0, 0, 0, 32'h0FA0, 32'h0FA0, 32'h0F90, 3};
  always #10 pclk = ~pclk;
  exit_reverse_path_motor_ctrl #(.TICK_CYCLES(10), .US_TICK(1)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fuser_transport_sensor(fus), .reverse_sensor_1(rs1), .reverse_sensor_2(rs2),
    .gate_solenoid(gate), .exit_phase_a(ph[0]), .exit_phase_b(ph[1]), .exit_phase_c(ph[2]),
    .exit_phase_d(ph[3]), .exit_const_speed_n(ecs), .rev_ref_clock(rck), .rev_enable_n(ren),
    .rev_const_speed_n(rcs), .rev_direction(rdir));
  exit_rev_far_side far (.pclk(pclk), .rev_ref_clock(rck), .rev_enable_n(ren), .rev_direction(rdir),
    .exit_phase(ph), .exit_power(pw), .rev_pulse_a(pa), .rev_pulse_b(pb), .rev_pulse_a_bar(pab),
    .rev_pulse_b_bar(pbb));
  // ----
  // Tasks
  // ----
  task automatic test_done();
    if (error_cnt == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] x);
    cmp_count++;
    if (seen !== x) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", s, x, seen);
    end
  endtask
  // Request held until pready seen high at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    chk("pready", pready, 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
    apb(1'b0, a, 32'h0);
    chk("prdata", rdat, x);
    chk("pslverr", rerr, xe);
  endtask
  // Poll the sequencer state, bounded
  task automatic wst(input logic [2:0] s);
    int k;
    k = 0;
    do begin
      apb(1'b0, 8'h08, 32'h0);
      k++;
    end while (rdat[2:0] !== s && k < 2500);
    chk("state", rdat[2:0], s);
    // Let the registered pins of the new state settle
    repeat (4) @(posedge pclk);
  endtask
  // ----
  // Tests
  // ----
  initial begin
    repeat (50000) @(posedge pclk);
    error_cnt++;
    test_done();
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, fus, rs1, rs2} = '0;
    presetn = 1'b0;
    void'($urandom(34));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("pins", {gate, ph, ecs, rck, ren, rcs, rdir}, 10'h004);
    for (i = 0; i < 7; i++) if (i != 1) rd(8'(i * 4), m[i], 1'b0);
    rd(8'h1C, 32'h0, 1'b1);
    apb(1'b1, 8'hF0, 32'hFFFF_FFFF);
    chk("werr", rerr, 1'b1);
    apb(1'b1, 8'h08, 32'hFFFF);
    rd(8'h08, 32'h0, 1'b0);
    for (i = 3; i < 7; i++) begin
      v = $urandom;
      apb(1'b1, 8'(i * 4), v);
      m[i] = v & 32'hFFFF;
      rd(8'(i * 4), m[i], 1'b0);
      apb(1'b1, 8'(i * 4), cfg[i]);
    end
    // Manual runs; run and direction bits drop in one write, the controller keeps direction until stopped
    apb(1'b1, 8'h00, 32'h6);
    rd(8'h00, 32'h6, 1'b0);
    repeat (8) @(posedge pclk);
    chk("rev", {ren, rdir}, 2'b01);
    apb(1'b1, 8'h00, 32'h1);
    for (n = 0; n < 20000 && !(ren && ecs); n++) @(posedge pclk);
    chk("exit", {ren, ecs, ph != 4'h0, pw == ph}, 4'hF);
    chk("pulse", {pa, pb, pab, pbb}, 4'h0);
    apb(1'b1, 8'h00, 32'h0);
    for (n = 0; n < 20000 && ph != 4'h0; n++) @(posedge pclk);
    chk("stop", {ph, ecs}, 5'h0);
    // Reversed sheet leaving the machine
    rs1 <= 1'b1;
    fus <= 1'b1;
    apb(1'b1, 8'h04, 32'h1);
    wst(3'h1);
    chk("tail", {gate, ren, rdir}, 3'b000);
    apb(1'b1, 8'h04, 32'h2);
    wst(3'h1);
    fus <= 1'b0;
    wst(3'h3);
    repeat (3) @(posedge pclk);
    chk("fast", {ren, rcs}, 2'b00);
    wst(3'h5);
    chk("back", {ren, rdir, gate, ph != 4'h0}, 4'b0101);
    rs1 <= 1'b0;
    wst(3'h0);
    // Duplex: handover, then straight second pass
    fus <= 1'b1;
    apb(1'b1, 8'h04, 32'h3);
    wst(3'h1);
    fus <= 1'b0;
    wst(3'h7);
    chk("hand", {ren, rdir, gate, pa ^ pab}, 4'b0101);
    rs2 <= 1'b1;
    wst(3'h0);
    fus <= 1'b1;
    apb(1'b1, 8'h04, 32'h0);
    wst(3'h4);
    chk("straight", {gate, ph != 4'h0}, 2'b11);
    fus <= 1'b0;
    wst(3'h0);
    chk("rest", gate, 1'b0);
    test_done();
  end
endmodule // test_exit_reverse_path_motor_ctrl
`default_nettype wire
